// ===== shared/usb_ep_cfg.svh
// Notes on behaviour
// - mode 0001 acks SETUP, naks IN and OUT
// - checked OUT acks only zero-length toggle-one data
// - transmit-count IN sends the endpoint byte count
// - transmit-zero IN sends an empty data packet
// - ignored tokens get no handshake at all
// - SETUP-accepting modes ack every valid SETUP
// - mode 1111 becomes 1110 after acked status OUT
// - accepted SETUP forces endpoint mode to 0001
// - reset disables all endpoints; disabled stays disabled
// - control endpoint keeps SETUP, IN, OUT status bits
// - only valid transactions get any response
// - interrupt on completion or on buffer corruption
// - valid data: count up to size plus two
// - OUT endpoints ignore IN, IN endpoints ignore OUT
// - IN/OUT status at end, SETUP at data start
// - acked control transfer locks mode and count writes
// - a later CPU read releases the write lock
// - bit 7 stall turns modes 1001 and 1101 into STALL, not on endpoint 0
// - oversize SETUP: no handshake, but fields, status and interrupt still update
// - mode 1011 becomes 0001 after acked OUT
// - mode 1101 becomes 1100 after acked IN
// - mode 1001 becomes 1000 after acked OUT
`ifndef USB_EP_CFG_SVH
`define USB_EP_CFG_SVH
// mode encodings
`define MODE_DISABLE 4'h0
`define MODE_NAK_INOUT 4'h1
`define MODE_STATUS_OUT 4'h2
`define MODE_STALL_INOUT 4'h3
`define MODE_IGNORE_INOUT 4'h4
`define MODE_RSVD_OUT 4'h5
`define MODE_STATUS_IN 4'h6
`define MODE_RSVD_IN 4'h7
`define MODE_NAK_OUT 4'h8
`define MODE_ACK_OUT 4'h9
`define MODE_NAK_OUT_STATUS_IN 4'hA
`define MODE_ACK_OUT_NAK_IN 4'hB
`define MODE_NAK_IN 4'hC
`define MODE_ACK_IN 4'hD
`define MODE_NAK_IN_STATUS_OUT 4'hE
`define MODE_ACK_IN_STATUS_OUT 4'hF
// register fields and resets
`define MODE_STALL_BIT 7
`define CNT_TOGGLE_BIT 7
`define CNT_VALID_BIT 6
`define MODE_RESET 8'h00
`define COUNT_RESET 8'h00
// packet size limits, crc bytes included
`define MAX_PKT_COUNT 5'h0A
`define CRC_BYTES 5'h02
`define NUM_EP 3
`define FIFO_DEPTH 16
`endif

// ===== shared/usb_ep_pkg.sv
package usb_ep_pkg;
  // token type carried with each event
  typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} tok_t;
  // engine answer; act_check is internal only
  typedef enum logic [2:0] {ACT_IGNORE, ACT_ACK, ACT_NAK, ACT_STALL, ACT_CHECK, ACT_TX_COUNT, ACT_TX_ZERO} act_t;
  // transaction events from the packet layer
  typedef struct packed {
    logic in_token;
    logic setup_begin;
    logic data_end;
    logic in_done;
    logic in_acked;
    logic [1:0] ep;
    tok_t tok;
    logic [4:0] count;
    logic toggle;
    logic crc_ok;
    logic err_ok;
    logic addr_ok;
  } usb_event_t;
  // answer to the packet layer
  typedef struct packed {
    logic valid;
    act_t code;
    logic [3:0] len;
  } usb_resp_t;
endpackage : usb_ep_pkg

// ===== design/usb_endpoint_mode_engine.sv
`timescale 1ns/100ps
`include "usb_ep_cfg.svh"

// byte fifo between receive deserializer and endpoint buffer
module usb_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // pointer width; depth must be a power of two so the pointers wrap cleanly
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_ptr_r; // next slot to fill
  logic [AW-1:0] rd_ptr_r; // next slot to drain
  logic [AW:0] used_r; // words held
  // a word moves on either side only when valid meets ready
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // read port is a plain mux; the word is good whenever out_valid is high
  assign out_data = mem[rd_ptr_r];

  // data store, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and flags; ready and valid held as flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      used_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      used_r <= used_r + (AW+1)'(push) - (AW+1)'(pop);
      in_ready <= (used_r + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
      out_valid <= (used_r + (AW+1)'(push) - (AW+1)'(pop)) != '0;
    end
  end
endmodule : usb_rx_fifo

module usb_endpoint_mode_engine import usb_ep_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // transaction events from the packet layer
  input wire usb_event_t ev,
  // handshake or data answer
  output usb_resp_t resp,
  // cpu side access to mode and count registers
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [1:0] cpu_ep,
  input wire logic cpu_sel_count,
  input wire logic [7:0] cpu_wdata,
  // register contents and status
  output logic [`NUM_EP-1:0][7:0] ep_mode,
  output logic [`NUM_EP-1:0][7:0] ep_count,
  output logic [2:0] ctrl_tok_status,
  output logic write_locked,
  output logic irq,
  // received data stream
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  output logic [7:0] rx_out_data,
  output logic rx_out_valid,
  input wire logic rx_out_ready
);

  // answer table per mode and token
  function automatic act_t decode(input logic [3:0] m, input logic stall, input tok_t t);
    act_t a;
    a = ACT_IGNORE;
    case (t)
      TOK_SETUP: begin
        case (m)
          `MODE_NAK_INOUT, `MODE_STATUS_OUT, `MODE_STALL_INOUT, `MODE_IGNORE_INOUT, `MODE_STATUS_IN,
          `MODE_NAK_OUT_STATUS_IN, `MODE_ACK_OUT_NAK_IN, `MODE_NAK_IN_STATUS_OUT,
          `MODE_ACK_IN_STATUS_OUT: a = ACT_ACK;
          default: a = ACT_IGNORE;
        endcase
      end
      TOK_IN: begin
        case (m)
          `MODE_NAK_INOUT, `MODE_ACK_OUT_NAK_IN, `MODE_NAK_IN, `MODE_NAK_IN_STATUS_OUT: a = ACT_NAK;
          `MODE_STATUS_OUT, `MODE_STALL_INOUT: a = ACT_STALL;
          `MODE_STATUS_IN, `MODE_NAK_OUT_STATUS_IN: a = ACT_TX_ZERO;
          `MODE_RSVD_IN, `MODE_ACK_IN_STATUS_OUT: a = ACT_TX_COUNT;
          `MODE_ACK_IN: a = stall ? ACT_STALL : ACT_TX_COUNT;
          default: a = ACT_IGNORE;
        endcase
      end
      default: begin
        case (m)
          `MODE_NAK_INOUT, `MODE_NAK_OUT, `MODE_NAK_OUT_STATUS_IN: a = ACT_NAK;
          `MODE_STATUS_OUT, `MODE_NAK_IN_STATUS_OUT, `MODE_ACK_IN_STATUS_OUT: a = ACT_CHECK;
          `MODE_STALL_INOUT, `MODE_STATUS_IN: a = ACT_STALL;
          `MODE_RSVD_OUT, `MODE_ACK_OUT_NAK_IN: a = ACT_ACK;
          `MODE_ACK_OUT: a = stall ? ACT_STALL : ACT_ACK;
          default: a = ACT_IGNORE;
        endcase
      end
    endcase
    return a;
  endfunction : decode

  // mode left behind by the engine after an ack
  // only applied on an acked SETUP or OUT, or an IN the host acked; any other result is discarded
  function automatic logic [3:0] after_ack(input logic [3:0] m, input tok_t t);
    logic [3:0] n;
    n = m;
    if (t == TOK_SETUP) begin
      if (m != `MODE_DISABLE) n = `MODE_NAK_INOUT;
    end else if (t == TOK_OUT) begin
      if (m == `MODE_ACK_OUT_NAK_IN) n = `MODE_NAK_INOUT;
      else if (m == `MODE_ACK_OUT) n = `MODE_NAK_OUT;
      else if (m == `MODE_ACK_IN_STATUS_OUT) n = `MODE_NAK_IN_STATUS_OUT;
    end else begin
      if (m == `MODE_ACK_IN) n = `MODE_NAK_IN;
      else if (m == `MODE_ACK_IN_STATUS_OUT) n = `MODE_NAK_IN_STATUS_OUT;
    end
    return n;
  endfunction : after_ack

  // register state
  logic [`NUM_EP-1:0][7:0] mode_r; // stall bit and mode per endpoint
  logic [`NUM_EP-1:0][7:0] count_r; // toggle, valid, byte count
  logic [2:0] tok_status_r; // {setup, in, out} of control endpoint
  logic lock_r; // control endpoint write lock
  logic irq_r; // one-cycle interrupt pulse
  usb_resp_t resp_r; // registered answer

  // event decode; stall only exists on non-control endpoints
  wire [3:0] ev_mode = mode_r[ev.ep][3:0];
  // control endpoint has no stall bit, so bit 7 there is never trusted
  wire ev_stall = mode_r[ev.ep][`MODE_STALL_BIT] & (ev.ep != 2'd0);
  act_t ev_act;
  assign ev_act = decode(ev_mode, ev_stall, ev.tok);
  wire ev_ctrl = ev.ep == 2'd0;
  wire is_setup = ev.tok == TOK_SETUP;
  wire is_in = ev.tok == TOK_IN;

  // data packet checks
  wire pkt_valid = ev.crc_ok & ev.err_ok & (ev.count <= `MAX_PKT_COUNT);
  wire zero_tog1 = (ev.count == `CRC_BYTES) & ev.toggle;
  act_t out_act;
  assign out_act = (ev_act == ACT_CHECK) ? (zero_tog1 ? ACT_ACK : ACT_STALL) : ev_act;
  // stored length drops the two crc bytes; short packets clamp to zero
  wire [4:0] payload = (ev.count > `CRC_BYTES) ? ev.count - `CRC_BYTES : 5'h00;

  // transaction outcomes
  wire data_hit = ev.data_end & ~is_in & (ev_act != ACT_IGNORE);
  wire data_resp = data_hit & pkt_valid;
  wire data_acked = data_resp & (out_act == ACT_ACK);
  wire data_update = data_hit & (is_setup | out_act == ACT_ACK);
  wire in_resp = ev.in_token & is_in & (ev_act != ACT_IGNORE);
  // host ack to our data closes an in transaction
  wire in_acked = ev.in_done & ev.in_acked & is_in;
  wire eng_wr = data_acked | in_acked;
  wire [3:0] eng_mode = after_ack(ev_mode, ev.tok);
  wire ack_ctrl = eng_wr & ev_ctrl;
  // a bad crc to a matched address means the receive buffer was overwritten
  wire corrupt = ev.data_end & ~is_in & ev.addr_ok & ~ev.crc_ok;
  wire irq_set = (data_hit & (pkt_valid | is_setup)) | ev.in_done | corrupt;

  // cpu access gating; a read in the locking cycle does not unlock
  // only the control endpoint locks; the others take writes at any time
  wire cpu_ctrl = cpu_ep == 2'd0;
  wire cpu_blocked = cpu_ctrl & lock_r;
  wire cpu_mode_wr = cpu_wr & ~cpu_sel_count & ~cpu_blocked;
  wire cpu_cnt_wr = cpu_wr & cpu_sel_count & ~cpu_blocked;
  wire unlock = cpu_rd & cpu_ctrl & ~ack_ctrl;

  // answer code and length; setup answers only with ack
  // in answers follow the mode alone, data answers follow the packet checks too
  wire resp_fire = data_resp | in_resp;
  act_t resp_code;
  assign resp_code = in_resp ? ev_act : out_act;
  wire [3:0] resp_len = (in_resp & ev_act == ACT_TX_COUNT) ? count_r[ev.ep][3:0] : 4'h0;

  // mode registers, engine before cpu
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_r <= {`NUM_EP{`MODE_RESET}};
    end else begin
      for (int e = 0; e < `NUM_EP; e++) begin
        if (eng_wr & (ev.ep == 2'(e))) begin
          mode_r[e][3:0] <= eng_mode;
        end else if (cpu_mode_wr & (cpu_ep == 2'(e))) begin
          mode_r[e] <= (e == 0) ? {4'h0, cpu_wdata[3:0]} : cpu_wdata;
        end
      end
    end
  end

  // count registers, engine fields before cpu
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_r <= {`NUM_EP{`COUNT_RESET}};
    end else begin
      for (int e = 0; e < `NUM_EP; e++) begin
        if (data_update & (ev.ep == 2'(e))) begin
          count_r[e] <= {ev.toggle, pkt_valid, 2'b00, payload[3:0]};
        end else if (cpu_cnt_wr & (cpu_ep == 2'(e))) begin
          count_r[e] <= cpu_wdata;
        end
      end
    end
  end

  // control endpoint token status: setup early, in/out at the end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tok_status_r <= 3'h0;
    end else if (ev.setup_begin & ev_ctrl & is_setup & ev_act == ACT_ACK) begin
      tok_status_r <= 3'h4;
    end else if (ev.in_done & ev_ctrl & is_in) begin
      tok_status_r <= 3'h2;
    end else if (data_resp & ev_ctrl & ev.tok == TOK_OUT) begin
      tok_status_r <= 3'h1;
    end
  end

  // a read racing the locking ack must not open the lock early
  // write lock, set beats release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_r <= 1'b0;
    end else if (ack_ctrl) begin
      lock_r <= 1'b1;
    end else if (unlock) begin
      lock_r <= 1'b0;
    end
  end

  // both pulses last one cycle; the packet layer must take them at once
  // answer and interrupt pulses
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      resp_r <= '0;
      irq_r <= 1'b0;
    end else begin
      resp_r <= '{valid: resp_fire, code: resp_fire ? resp_code : ACT_IGNORE, len: resp_len};
      irq_r <= irq_set;
    end
  end

  // received data buffering
  usb_rx_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) rx_fifo (
    .clock(clock),
    .reset(reset),
    .in_data(rx_in_data),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .out_data(rx_out_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready)
  );

  // outputs straight from flops
  assign ep_mode = mode_r;
  assign ep_count = count_r;
  assign ctrl_tok_status = tok_status_r;
  assign write_locked = lock_r;
  assign irq = irq_r;
  assign resp = resp_r;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_SETUP_FORCE: assert property (ev.data_end & is_setup & pkt_valid & ev_act == ACT_ACK
    |=> mode_r[$past(ev.ep)][3:0] == `MODE_NAK_INOUT) else $error("setup did not force nak mode");
  AST_SETUP_ACK: assert property (ev.data_end & is_setup & pkt_valid & ev_act == ACT_ACK
    |=> resp.valid && resp.code == ACT_ACK) else $error("valid setup not acked");
  AST_OVERSIZE: assert property (ev.data_end & is_setup & ev.count > `MAX_PKT_COUNT & ev_act == ACT_ACK
    |=> !resp.valid && irq) else $error("oversize setup answered or silent");
  AST_INVALID_SILENT: assert property (ev.data_end & ~pkt_valid & ~ev.in_token
    |=> !resp.valid) else $error("invalid packet answered");
  AST_NAK_MODE_IN: assert property (ev.in_token & is_in & ev_mode == `MODE_NAK_INOUT
    |=> resp.valid && resp.code == ACT_NAK) else $error("nak mode did not nak in");
  AST_CHECK_OUT: assert property (ev.data_end & ev.tok == TOK_OUT & pkt_valid & ev_act == ACT_CHECK
    |=> resp.valid && resp.code == ($past(ev.count == `CRC_BYTES && ev.toggle) ? ACT_ACK : ACT_STALL))
    else $error("status out check wrong");
  AST_TX_LEN: assert property (ev.in_token & is_in & ev_act == ACT_TX_COUNT
    |=> resp.len == $past(count_r[ev.ep][3:0])) else $error("tx count length wrong");
  AST_LOCK_HOLD: assert property (lock_r & cpu_wr & cpu_ctrl & ~eng_wr & ~data_update
    |=> $stable(mode_r[0]) && $stable(count_r[0])) else $error("locked register written");
  AST_UNLOCK: assert property (lock_r & cpu_rd & cpu_ctrl & ~ack_ctrl
    |=> !lock_r) else $error("read did not unlock");
  AST_DISABLED_STAYS: assert property (mode_r[ev.ep][3:0] == `MODE_DISABLE & ~cpu_wr
    |=> $stable(mode_r)) else $error("disabled endpoint changed by engine");
  AST_ACK_IN_REWRITE: assert property (in_acked & ev_mode == `MODE_ACK_IN
    |=> mode_r[$past(ev.ep)][3:0] == `MODE_NAK_IN) else $error("ack in mode not rewritten");

  // answer checks
  AST_TX_ZERO: assert property (ev.in_token & is_in & ev_act == ACT_TX_ZERO
    |=> resp.valid && resp.code == ACT_TX_ZERO && resp.len == 4'h0) else $error("status in not zero length");
  AST_IGNORED_SILENT: assert property ((ev.in_token | ev.data_end) & ev_act == ACT_IGNORE
    |=> !resp.valid) else $error("ignored token answered");
  AST_VALID_ANSWERED: assert property (ev.data_end & ~is_in & ev.crc_ok & ev.err_ok & ev.count <= `MAX_PKT_COUNT
    & ev_act != ACT_IGNORE |=> resp.valid) else $error("valid data packet not answered");
  AST_IN_ON_OUT_EP: assert property (ev.in_token & is_in & (ev_mode == `MODE_NAK_OUT | ev_mode == `MODE_ACK_OUT)
    |=> !resp.valid) else $error("out endpoint answered an in");
  AST_STALL_IN: assert property (ev.in_token & is_in & ev_stall & ev_mode == `MODE_ACK_IN
    |=> resp.valid && resp.code == ACT_STALL) else $error("stalled endpoint did not stall in");

  // engine mode rewrites
  AST_OUT_REWRITE_B: assert property (data_acked & ev.tok == TOK_OUT & ev_mode == `MODE_ACK_OUT_NAK_IN
    |=> mode_r[$past(ev.ep)][3:0] == `MODE_NAK_INOUT) else $error("ack out nak in mode not rewritten");
  AST_OUT_REWRITE_9: assert property (data_acked & ev.tok == TOK_OUT & ev_mode == `MODE_ACK_OUT
    |=> mode_r[$past(ev.ep)][3:0] == `MODE_NAK_OUT) else $error("ack out mode not rewritten");
  AST_STATUS_OUT_REWRITE: assert property (data_acked & ev.tok == TOK_OUT & ev_mode == `MODE_ACK_IN_STATUS_OUT
    |=> mode_r[$past(ev.ep)][3:0] == `MODE_NAK_IN_STATUS_OUT) else $error("status out ack did not rewrite mode");

  // status, interrupt and lock
  AST_TOK_ONEHOT: assert property ($onehot0(tok_status_r)) else $error("token status not one-hot");
  AST_SETUP_STATUS: assert property (ev.setup_begin & ev_ctrl & is_setup & ev_act == ACT_ACK
    |=> tok_status_r == 3'h4) else $error("setup status not set at data start");
  AST_IN_STATUS: assert property (ev.in_done & ~ev.setup_begin & ev_ctrl & is_in
    |=> tok_status_r == 3'h2) else $error("in status not set at transaction end");
  AST_CORRUPT_IRQ: assert property (ev.data_end & ~is_in & ev.addr_ok & ~ev.crc_ok
    |=> irq) else $error("buffer corruption raised no interrupt");
  AST_SETUP_IRQ: assert property (ev.data_end & is_setup & pkt_valid & ev_act == ACT_ACK
    |=> irq) else $error("valid setup raised no interrupt");
  AST_DONE_IRQ: assert property (ev.in_done |=> irq) else $error("finished in raised no interrupt");
  AST_LOCK_SET: assert property (ack_ctrl |=> lock_r) else $error("acked control transfer did not lock");

endmodule : usb_endpoint_mode_engine

// ===== tb/usb_host_model.sv
`timescale 1ns/100ps
// host side of the link: issues token and data events, records the answer
module usb_host_model import usb_ep_pkg::*; (
  // clock
  input wire logic clock,
  // events towards the engine
  output usb_event_t ev,
  // engine answer
  input wire usb_resp_t resp
);
  // answer seen one cycle after the event
  usb_resp_t seen_r;
  // released field pattern, so stale values never look valid
  usb_event_t rel;

  initial ev = '0;

  // one event per call; the strobe drops after one edge so events never merge
  task automatic issue(input usb_event_t e);
    rel = usb_event_t'(~e);
    rel.in_token = 1'b0;
    rel.setup_begin = 1'b0;
    rel.data_end = 1'b0;
    rel.in_done = 1'b0;
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= rel;
    #1;
    seen_r = resp;
  endtask : issue
endmodule : usb_host_model

// ===== tb/testbench.sv
`timescale 1ns/100ps
`include "usb_ep_cfg.svh"
// sequence tests of endpoint mode handling, cpu lock and receive fifo
module testbench import usb_ep_pkg::*;;
  // clock and reset
  logic clock;
  logic reset;
  // engine ports
  usb_event_t ev;
  usb_resp_t resp;
  logic cpu_wr, cpu_rd, cpu_sel_count;
  logic [1:0] cpu_ep;
  logic [7:0] cpu_wdata;
  logic [`NUM_EP-1:0][7:0] ep_mode;
  logic [`NUM_EP-1:0][7:0] ep_count;
  logic [2:0] ctrl_tok_status;
  logic write_locked, irq;
  // fifo ports
  logic [7:0] rx_in_data, rx_out_data;
  logic rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
  // bookkeeping
  int mismatches, checked, n, k;
  logic rdy;

  usb_endpoint_mode_engine usb_endpoint_mode_engine_i (.clock(clock), .reset(reset), .ev(ev), .resp(resp),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_ep(cpu_ep), .cpu_sel_count(cpu_sel_count), .cpu_wdata(cpu_wdata),
    .ep_mode(ep_mode), .ep_count(ep_count), .ctrl_tok_status(ctrl_tok_status), .write_locked(write_locked),
    .irq(irq), .rx_in_data(rx_in_data), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
    .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready));
  usb_host_model usb_host_model_i (.clock(clock), .ev(ev), .resp(resp));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // value compare
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // answer compare; code and length only matter when an answer is due
  task automatic chk_resp(input logic v, input act_t c, input logic [3:0] len);
    usb_resp_t s;
    s = usb_host_model_i.seen_r;
    checked++;
    if (s.valid !== v || (v && (s.code !== c || s.len !== len))) begin
      mismatches++;
      $display("[FAIL] resp expected %b/%0d/%h seen %b/%0d/%h", v, c, len, s.valid, s.code, s.len);
    end
  endtask : chk_resp

  // kind: 0 in token, 1 data end, 2 in done acked, 3 setup begin, 4 in done not acked
  function automatic usb_event_t mk(input int kind, input logic [1:0] ep, input tok_t t, input logic [4:0] cnt,
    input logic tg, input logic ok);
    usb_event_t e;
    e = '0;
    e.in_token = (kind == 0);
    e.data_end = (kind == 1);
    e.in_done = (kind == 2) || (kind == 4);
    e.in_acked = (kind == 2);
    e.setup_begin = (kind == 3);
    e.ep = ep;
    e.tok = t;
    e.count = cnt;
    e.toggle = tg;
    e.crc_ok = ok;
    e.err_ok = 1'b1;
    e.addr_ok = 1'b1;
    return e;
  endfunction : mk

  // one host event, then answer and interrupt pulse in the following cycle
  task automatic txn(input int kind, input logic [1:0] ep, input tok_t t, input logic [4:0] cnt, input logic tg,
    input logic ok, input logic v, input act_t c, input logic [3:0] len, input logic i);
    usb_host_model_i.issue(mk(kind, ep, t, cnt, tg, ok));
    chk_resp(v, c, len);
    chk("irq", {7'h00, i}, {7'h00, irq});
  endtask : txn

  // register write, optionally preceded by the unlocking read
  task automatic reg_wr(input logic [1:0] ep, input logic sel, input logic [7:0] d, input logic unlock);
    @(posedge clock);
    cpu_rd <= unlock;
    cpu_ep <= ep;
    cpu_sel_count <= sel;
    @(posedge clock);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b1;
    cpu_wdata <= d;
    @(posedge clock);
    cpu_wr <= 1'b0;
    #1;
  endtask : reg_wr

  // verdict, reached from the end of the sequence only
  task automatic tally_and_finish();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    mismatches = 0;
    checked = 0;
    reset = 1'b1;
    {cpu_wr, cpu_rd, cpu_sel_count, cpu_ep, cpu_wdata} = '0;
    {rx_in_data, rx_in_valid, rx_out_ready} = '0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    #1;
    for (int e = 0; e < `NUM_EP; e++) begin
      chk("mode", 8'h00, ep_mode[e]);
      chk("count", 8'h00, ep_count[e]);
    end
    // disabled endpoints stay silent and unchanged
    txn(0, 2'd1, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b0);
    txn(1, 2'd0, TOK_OUT, 5'h02, 1'b1, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b0);
    chk("mode", 8'h00, ep_mode[0]);
    // control endpoint set to status out: setup acked and forces nak mode, then in and out naked
    reg_wr(2'd0, 1'b0, 8'h02, 1'b0);
    txn(3, 2'd0, TOK_SETUP, 5'h0A, 1'b0, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b0);
    chk("tok", 8'h04, {5'h00, ctrl_tok_status});
    txn(1, 2'd0, TOK_SETUP, 5'h0A, 1'b0, 1'b1, 1'b1, ACT_ACK, 4'h0, 1'b1);
    chk("mode", 8'h01, ep_mode[0]);
    chk("count", 8'h48, ep_count[0]);
    chk("lock", 8'h01, {7'h00, write_locked});
    reg_wr(2'd0, 1'b0, 8'h0F, 1'b0);
    chk("mode", 8'h01, ep_mode[0]);
    txn(0, 2'd0, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_NAK, 4'h0, 1'b0);
    chk("tok", 8'h04, {5'h00, ctrl_tok_status});
    txn(4, 2'd0, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b1);
    chk("tok", 8'h02, {5'h00, ctrl_tok_status});
    txn(1, 2'd0, TOK_OUT, 5'h02, 1'b1, 1'b1, 1'b1, ACT_NAK, 4'h0, 1'b1);
    chk("tok", 8'h01, {5'h00, ctrl_tok_status});
    // status out check in ack in mode; read first to unlock
    reg_wr(2'd0, 1'b0, 8'h0F, 1'b1);
    chk("mode", 8'h0F, ep_mode[0]);
    txn(0, 2'd0, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_TX_COUNT, 4'h8, 1'b0);
    txn(1, 2'd0, TOK_OUT, 5'h02, 1'b1, 1'b1, 1'b1, ACT_ACK, 4'h0, 1'b1);
    chk("mode", 8'h0E, ep_mode[0]);
    txn(1, 2'd0, TOK_OUT, 5'h02, 1'b0, 1'b1, 1'b1, ACT_STALL, 4'h0, 1'b1);
    txn(1, 2'd0, TOK_OUT, 5'h03, 1'b1, 1'b1, 1'b1, ACT_STALL, 4'h0, 1'b1);
    txn(1, 2'd0, TOK_OUT, 5'h02, 1'b1, 1'b0, 1'b0, ACT_IGNORE, 4'h0, 1'b1);
    // oversize setup: silent but recorded
    txn(3, 2'd0, TOK_SETUP, 5'h0B, 1'b1, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b0);
    txn(1, 2'd0, TOK_SETUP, 5'h0B, 1'b1, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b1);
    chk("tok", 8'h04, {5'h00, ctrl_tok_status});
    chk("count", 8'h89, ep_count[0] & 8'hBF);
    // status in, ack out, ignore and stall modes
    reg_wr(2'd0, 1'b0, 8'h06, 1'b1);
    txn(0, 2'd0, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_TX_ZERO, 4'h0, 1'b0);
    reg_wr(2'd0, 1'b0, 8'h0B, 1'b1);
    txn(1, 2'd0, TOK_OUT, 5'h04, 1'b0, 1'b1, 1'b1, ACT_ACK, 4'h0, 1'b1);
    chk("mode", 8'h01, ep_mode[0]);
    chk("count", 8'h42, ep_count[0]);
    reg_wr(2'd0, 1'b0, 8'h04, 1'b1);
    txn(0, 2'd0, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b0);
    reg_wr(2'd0, 1'b0, 8'h03, 1'b1);
    txn(0, 2'd0, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_STALL, 4'h0, 1'b0);
    txn(1, 2'd0, TOK_OUT, 5'h02, 1'b1, 1'b1, 1'b1, ACT_STALL, 4'h0, 1'b1);
    reg_wr(2'd0, 1'b0, 8'h0A, 1'b1);
    txn(0, 2'd0, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_TX_ZERO, 4'h0, 1'b0);
    txn(1, 2'd0, TOK_OUT, 5'h02, 1'b1, 1'b1, 1'b1, ACT_NAK, 4'h0, 1'b1);
    // non-control endpoints never lock; ack out, ack in and stall modes
    reg_wr(2'd1, 1'b0, 8'h09, 1'b0);
    txn(0, 2'd1, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b0);
    txn(1, 2'd1, TOK_OUT, 5'h06, 1'b1, 1'b1, 1'b1, ACT_ACK, 4'h0, 1'b1);
    chk("mode", 8'h08, ep_mode[1]);
    chk("count", 8'hC4, ep_count[1]);
    txn(1, 2'd1, TOK_OUT, 5'h02, 1'b0, 1'b1, 1'b1, ACT_NAK, 4'h0, 1'b1);
    reg_wr(2'd1, 1'b0, 8'h89, 1'b0);
    txn(1, 2'd1, TOK_OUT, 5'h02, 1'b0, 1'b1, 1'b1, ACT_STALL, 4'h0, 1'b1);
    reg_wr(2'd2, 1'b1, 8'h05, 1'b0);
    reg_wr(2'd2, 1'b0, 8'h0D, 1'b0);
    txn(1, 2'd2, TOK_OUT, 5'h02, 1'b0, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b0);
    txn(0, 2'd2, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_TX_COUNT, 4'h5, 1'b0);
    txn(2, 2'd2, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b0, ACT_IGNORE, 4'h0, 1'b1);
    chk("mode", 8'h0C, ep_mode[2]);
    txn(0, 2'd2, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_NAK, 4'h0, 1'b0);
    reg_wr(2'd2, 1'b0, 8'h8D, 1'b0);
    txn(0, 2'd2, TOK_IN, 5'h00, 1'b0, 1'b1, 1'b1, ACT_STALL, 4'h0, 1'b0);
    // fifo: fill with the drain stalled until refused, then drain empty
    @(posedge clock);
    rx_in_valid <= 1'b1;
    n = 0;
    repeat (24) begin
      #1 rdy = rx_in_ready;
      @(posedge clock);
      if (rdy) begin
        n++;
        rx_in_data <= 8'(n);
      end
    end
    rx_in_valid <= 1'b0;
    chk("pushed", 8'd16, 8'(n));
    rx_out_ready <= 1'b1;
    k = 0;
    repeat (60) begin
      #1;
      if (rx_out_valid === 1'b1) begin
        chk("rx data", 8'(k), rx_out_data);
        k++;
      end
      @(posedge clock);
    end
    chk("popped", 8'd16, 8'(k));
    tally_and_finish();
  end
endmodule : testbench
